/* wkt_pkg.sv */
// constants and types shared by the wake-up timer and vector block
`default_nettype none
package wkt_pkg;
    // register byte addresses
    localparam logic [7:0] WKT_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] WKT_ADDR_COUNT  = 8'h04;
    localparam logic [7:0] WKT_ADDR_STATUS = 8'h08;
    localparam logic [7:0] WKT_ADDR_MASK   = 8'h0c;
    localparam logic [7:0] WKT_ADDR_VECTOR = 8'h10;
    // control and status register fields
    localparam int WKT_CTRL_FLAG_BIT  = 7;
    localparam int WKT_CTRL_IE_BIT    = 6;
    localparam int WKT_CTRL_CLEAR_BIT = 4;
    localparam int WKT_CTRL_ON_BIT    = 3;
    localparam int WKT_CTRL_PS_MSB    = 2;
    localparam int WKT_CTRL_PS_LSB    = 0;
    localparam int WKT_STAT_OVF_BIT   = 0;
    // reset values
    localparam logic [2:0] WKT_PS_RESET   = 3'h0;
    localparam logic       WKT_ON_RESET   = 1'b0;
    localparam logic       WKT_IE_RESET   = 1'b0;
    localparam logic       WKT_FLAG_RESET = 1'b0;
    // oscillator cycles for code 000; higher codes shift it left
    localparam int unsigned WKT_BASE_OSC_CYCLES = 4096;
    localparam int          WKT_CNT_W           = 19;
    // vector table
    localparam logic [15:0] WKT_VEC_RESET    = 16'h0000;
    localparam logic [15:0] WKT_VEC_EXT0     = 16'h0002;
    localparam logic [15:0] WKT_VEC_PC_A     = 16'h0004;
    localparam logic [15:0] WKT_VEC_PC_B     = 16'h0006;
    localparam logic [15:0] WKT_VEC_WAKEUP   = 16'h000a;
    localparam int          WKT_RST_SRC_W    = 5;
    // ahb-lite encodings
    localparam logic [1:0]  WKT_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  WKT_HTRANS_SEQ    = 2'h3;
    localparam logic        WKT_HRESP_OKAY    = 1'b0;

    typedef enum logic [2:0] {
        WKT_SRC_NONE   = 3'b000,
        WKT_SRC_RESET  = 3'b001,
        WKT_SRC_EXT0   = 3'b010,
        WKT_SRC_PC_A   = 3'b011,
        WKT_SRC_PC_B   = 3'b100,
        WKT_SRC_WAKEUP = 3'b101
    } wkt_src_t;
endpackage
`default_nettype wire

/* wkt_sync.sv */
// two-flop synchroniser for asynchronous level inputs
`default_nettype none
module wkt_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // meta_q feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* wkt_top.sv */
// wake-up timer with vector selection behind an ahb-lite slave
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`default_nettype none
module wkt_top
    import wkt_pkg::*;
#(
    parameter int unsigned BASE_OSC_CYCLES = wkt_pkg::WKT_BASE_OSC_CYCLES
) (
    input  wire logic                               clk,
    input  wire logic                               rst_n,
    input  wire logic                               hsel,
    input  wire logic [31:0]                        haddr,
    input  wire logic [1:0]                         htrans,
    input  wire logic                               hwrite,
    input  wire logic [2:0]                         hsize,
    input  wire logic [31:0]                        hwdata,
    input  wire logic                               hready,
    output var  logic                               hreadyout,
    output var  logic                               hresp,
    output var  logic [31:0]                        hrdata,
    input  wire logic                               osc_clk_pin,
    input  wire logic [wkt_pkg::WKT_RST_SRC_W-1:0]  reset_source_pins,
    input  wire logic                               external_interrupt_zero,
    input  wire logic                               pin_change_irq_a,
    input  wire logic                               pin_change_irq_b,
    input  wire logic                               global_irq_enable,
    input  wire logic                               vector_taken,
    output var  logic                               irq,
    output var  logic                               vector_request,
    output var  logic                               cpu_reset_request,
    output var  logic [15:0]                        vector_address
);
    import wkt_pkg::*;

    // ---------------- pin synchronisers ----------------
    localparam int PIN_W = WKT_RST_SRC_W + 4;

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_sync;
    logic             osc_s;
    logic             ext0_s;
    logic             pca_s;
    logic             pcb_s;
    logic [WKT_RST_SRC_W-1:0] rst_src_s;

    assign pins_raw = {reset_source_pins, pin_change_irq_b,
                       pin_change_irq_a, external_interrupt_zero,
                       osc_clk_pin};

    wkt_sync #(
        .W (PIN_W)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    assign osc_s     = pins_sync[0];
    assign ext0_s    = pins_sync[1];
    assign pca_s     = pins_sync[2];
    assign pcb_s     = pins_sync[3];
    assign rst_src_s = pins_sync[PIN_W-1:4];

    // ---------------- functions ----------------
    // last count value before overflow for a prescale code
    function automatic logic [WKT_CNT_W-1:0] terminal_count(
        input logic [2:0] code
    );
        logic [WKT_CNT_W:0] cycles;
        cycles = (WKT_CNT_W+1)'(BASE_OSC_CYCLES) << code;
        terminal_count = WKT_CNT_W'(cycles - (WKT_CNT_W+1)'(1));
    endfunction

    function automatic logic is_reg(
        input logic [31:0] addr,
        input logic [7:0]  offs
    );
        is_reg = (addr[7:0] == offs) && (addr[31:8] == 24'h000000);
    endfunction

    // ---------------- ahb-lite address phase ----------------
    logic        xfer_go;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic        rd_pend_q;
    logic [31:0] rd_addr_q;

    assign xfer_go = hsel && hready &&
                     (htrans == WKT_HTRANS_NONSEQ ||
                      htrans == WKT_HTRANS_SEQ);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rd_pend_q <= 1'b0;
            rd_addr_q <= 32'h00000000;
        end else begin
            wr_pend_q <= xfer_go && hwrite && (haddr[31:8] == 24'h000000);
            wr_addr_q <= haddr[7:0];
            rd_pend_q <= xfer_go && !hwrite;
            rd_addr_q <= haddr;
        end
    end

    // write strobes in the data phase
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;

    assign wr_ctrl   = wr_pend_q && (wr_addr_q == WKT_ADDR_CTRL);
    assign wr_status = wr_pend_q && (wr_addr_q == WKT_ADDR_STATUS);
    assign wr_mask   = wr_pend_q && (wr_addr_q == WKT_ADDR_MASK);

    // ---------------- control state ----------------
    logic [2:0] prescale_q;
    logic       timer_on_q;
    logic       irq_enable_q;
    logic       irq_enable_d;
    logic       ovf_flag_q;
    logic       ovf_flag_d;
    logic       clear_pulse;
    logic       flag_w1c;
    logic       flag_vec_clr;

    // clear bit is a pulse only; it is never stored
    assign clear_pulse = wr_ctrl && hwdata[WKT_CTRL_CLEAR_BIT];

    // ctrl and mask share one enable; irq follows the new value at once
    assign irq_enable_d = wr_ctrl ? hwdata[WKT_CTRL_IE_BIT] :
                          wr_mask ? hwdata[WKT_STAT_OVF_BIT] :
                          irq_enable_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prescale_q   <= WKT_PS_RESET;
            timer_on_q   <= WKT_ON_RESET;
            irq_enable_q <= WKT_IE_RESET;
        end else begin
            if (wr_ctrl) begin
                prescale_q <= hwdata[WKT_CTRL_PS_MSB:WKT_CTRL_PS_LSB];
                timer_on_q <= hwdata[WKT_CTRL_ON_BIT];
            end
            irq_enable_q <= irq_enable_d;
        end
    end

    // ---------------- oscillator edge and counter ----------------
    logic                 osc_d1_q;
    logic                 osc_rise;
    logic [WKT_CNT_W-1:0] count_q;
    logic [WKT_CNT_W-1:0] count_d;
    logic                 at_terminal;
    logic                 overflow;

    // edge taken from the second sync stage only
    assign osc_rise    = osc_s && !osc_d1_q;
    assign at_terminal = (count_q >= terminal_count(prescale_q));
    assign overflow    = timer_on_q && osc_rise && at_terminal
                         && !clear_pulse;

    // clear wins over an edge in the same cycle
    assign count_d = clear_pulse                ? '0 :
                     !timer_on_q                ? count_q :
                     !osc_rise                  ? count_q :
                     at_terminal                ? '0 :
                     count_q + WKT_CNT_W'(1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_d1_q <= 1'b0;
            count_q  <= '0;
        end else begin
            osc_d1_q <= osc_s;
            count_q  <= count_d;
        end
    end

    // ---------------- overflow flag ----------------
    // set beats either clear arriving in the same cycle
    assign flag_w1c = (wr_ctrl && hwdata[WKT_CTRL_FLAG_BIT]) ||
                      (wr_status && hwdata[WKT_STAT_OVF_BIT]);
    assign ovf_flag_d = overflow ||
                        (ovf_flag_q && !flag_w1c && !flag_vec_clr);

    always_ff @(posedge clk) begin
        if (!rst_n)
            ovf_flag_q <= WKT_FLAG_RESET;
        else
            ovf_flag_q <= ovf_flag_d;
    end

    // ---------------- vector selection ----------------
    wkt_src_t    src_sel;
    wkt_src_t    src_q;
    logic        any_reset;
    logic        wake_pending;
    logic        vec_take;
    logic [15:0] vec_sel;

    assign any_reset    = |rst_src_s;
    assign wake_pending = ovf_flag_q && irq_enable_q &&
                          global_irq_enable;

    // reset beats everything, then the lowest vector wins
    assign src_sel = any_reset                        ? WKT_SRC_RESET :
                     (global_irq_enable && ext0_s)    ? WKT_SRC_EXT0 :
                     (global_irq_enable && pca_s)     ? WKT_SRC_PC_A :
                     (global_irq_enable && pcb_s)     ? WKT_SRC_PC_B :
                     wake_pending                     ? WKT_SRC_WAKEUP :
                     WKT_SRC_NONE;

    always_comb begin
        case (src_sel)
            WKT_SRC_RESET:  vec_sel = WKT_VEC_RESET;
            WKT_SRC_EXT0:   vec_sel = WKT_VEC_EXT0;
            WKT_SRC_PC_A:   vec_sel = WKT_VEC_PC_A;
            WKT_SRC_PC_B:   vec_sel = WKT_VEC_PC_B;
            WKT_SRC_WAKEUP: vec_sel = WKT_VEC_WAKEUP;
            default:        vec_sel = WKT_VEC_RESET;
        endcase
    end

    // the taken vector is the one selected last cycle and presented now
    assign vec_take     = vector_taken && vector_request;
    assign flag_vec_clr = vec_take &&
                          (src_q == WKT_SRC_WAKEUP);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_q             <= WKT_SRC_NONE;
            vector_address    <= WKT_VEC_RESET;
            vector_request    <= 1'b0;
            cpu_reset_request <= 1'b0;
            irq               <= 1'b0;
        end else begin
            src_q             <= src_sel;
            // address idles at zero whenever no request stands
            vector_address    <= vec_take ? WKT_VEC_RESET : vec_sel;
            // drop the request the cycle after it is taken
            vector_request    <= (src_sel != WKT_SRC_NONE) && !vec_take;
            cpu_reset_request <= any_reset;
            irq               <= ovf_flag_d && irq_enable_d;
        end
    end

    // ---------------- read data phase ----------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h00000000;
        if (is_reg(rd_addr_q, WKT_ADDR_CTRL)) begin
            rd_mux[WKT_CTRL_FLAG_BIT] = ovf_flag_q;
            rd_mux[WKT_CTRL_IE_BIT]   = irq_enable_q;
            rd_mux[WKT_CTRL_ON_BIT]   = timer_on_q;
            rd_mux[WKT_CTRL_PS_MSB:WKT_CTRL_PS_LSB] = prescale_q;
        end else if (is_reg(rd_addr_q, WKT_ADDR_COUNT)) begin
            rd_mux[WKT_CNT_W-1:0] = count_q;
        end else if (is_reg(rd_addr_q, WKT_ADDR_STATUS)) begin
            rd_mux[WKT_STAT_OVF_BIT] = ovf_flag_q;
        end else if (is_reg(rd_addr_q, WKT_ADDR_MASK)) begin
            rd_mux[WKT_STAT_OVF_BIT] = irq_enable_q;
        end else if (is_reg(rd_addr_q, WKT_ADDR_VECTOR)) begin
            rd_mux[15:0] = vector_address;
        end
    end

    // one wait state on reads, so a read right after a write
    // sees the written value
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp     <= WKT_HRESP_OKAY;
            hrdata    <= 32'h00000000;
        end else begin
            hresp <= WKT_HRESP_OKAY;
            if (xfer_go && !hwrite) begin
                hreadyout <= 1'b0;
            end else if (rd_pend_q) begin
                hreadyout <= 1'b1;
                hrdata    <= rd_mux;
            end else begin
                hreadyout <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* wkt_chk_sva.sv */
// bound checker for the wake-up timer bus and vector outputs
`default_nettype none
module wkt_chk #(
    parameter int unsigned BASE_OSC_CYCLES = 16
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        global_irq_enable,
    input wire logic        vector_taken,
    input wire logic        irq,
    input wire logic        vector_request,
    input wire logic [15:0] vector_address
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence rd_s;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence wr_s;
        hsel && hready && htrans[1] && hwrite;
    endsequence
    // w1c of the status word, data phase included
    sequence w1c_s;
        wr_s ##0 (haddr == 32'h8) ##1 hwdata[0];
    endsequence

    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("slave response not okay");
    read_wait_a: assert property (rd_s |=> !hreadyout ##1 hreadyout)
        else $error("read not answered after one wait state");
    write_fast_a: assert property (wr_s |=> hreadyout)
        else $error("write stalled");
    unmapped_zero_a: assert property (rd_s ##0
        (haddr > 32'h10 && haddr < 32'h100) |=> ##1 (hrdata == 32'h0))
        else $error("unmapped read not zero");
    vec_taken_a: assert property (vector_request && vector_taken
        |=> !vector_request) else $error("request held after take");
    vec_legal_a: assert property (vector_request |-> vector_address
        inside {16'h0, 16'h2, 16'h4, 16'h6, 16'ha})
        else $error("vector address outside table");
    idle_vec_a: assert property (!vector_request |-> vector_address == 16'h0)
        else $error("vector address without request");
    irq_gate_a: assert property (vector_request
        && vector_address != 16'h0 |-> $past(global_irq_enable))
        else $error("interrupt vector without global enable");
    status_clear_a: assert property (w1c_s |=> !irq)
        else $error("irq stays after flag clear");
endmodule

bind wkt_top wkt_chk #(.BASE_OSC_CYCLES(BASE_OSC_CYCLES)) u_chk (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .global_irq_enable, .vector_taken, .irq,
    .vector_request, .vector_address
);
`default_nettype wire

/* testbench.sv */
// self-checking bench for the wake-up timer and vector block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import wkt_pkg::*;
    localparam int unsigned BASE = 16;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp, irq, vreq, creq;
    logic [31:0] hrdata, rd;
    logic [15:0] vaddr;
    logic        osc = 1'b0, run = 1'b0, gie = 1'b0, vtaken = 1'b0;
    logic        ext0 = 1'b0, pca = 1'b0, pcb = 1'b0;
    logic [4:0]  rsrc = 5'h0;
    logic [1:0]  div = 2'h0;
    int          n_mismatch = 0, tests_run = 0, n_edge = 0;

    wkt_top #(.BASE_OSC_CYCLES(BASE)) dut (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .osc_clk_pin(osc), .reset_source_pins(rsrc),
        .external_interrupt_zero(ext0), .pin_change_irq_a(pca),
        .pin_change_irq_b(pcb), .global_irq_enable(gie),
        .vector_taken(vtaken), .irq(irq), .vector_request(vreq),
        .cpu_reset_request(creq), .vector_address(vaddr)
    );

    always #4 clk = ~clk;

    // oscillator parks low when stopped, so no edge is left in flight
    always @(posedge clk) begin
        if (run || osc) begin
            div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
            if (div == 2'h2) begin
                osc <= ~osc;
                if (!osc)
                    n_edge <= n_edge + 1;
            end
        end
    end

    task automatic final_report;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= WKT_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rd, e);
    endtask

    // covers the two-flop sync plus output register with margin
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask

    task automatic wait_irq;
        @(posedge clk);
        for (int i = 0; i < 60000 && irq !== 1'b1; i++)
            @(posedge clk);
        check(32'(irq), 32'h1);
    endtask

    task automatic t_regs;
        rdc(WKT_ADDR_CTRL, 32'h0);
        rdc(WKT_ADDR_COUNT, 32'h0);
        rdc(WKT_ADDR_VECTOR, 32'h0);
        wr(WKT_ADDR_CTRL, 32'h37);
        rdc(WKT_ADDR_CTRL, 32'h07);
        wr(8'h14, 32'hff);
        rdc(8'h14, 32'h0);
        wr(WKT_ADDR_CTRL, 32'h0);
    endtask

    task automatic t_vec;
        ext0 <= 1'b1;
        pca <= 1'b1;
        pcb <= 1'b1;
        settle;
        check(32'(vreq), 32'h0);
        gie <= 1'b1;
        settle;
        check(32'(vaddr), 32'(WKT_VEC_EXT0));
        ext0 <= 1'b0;
        settle;
        check(32'(vaddr), 32'(WKT_VEC_PC_A));
        pca <= 1'b0;
        settle;
        check(32'(vaddr), 32'(WKT_VEC_PC_B));
        for (int i = 0; i < 5; i++) begin
            rsrc <= 5'(1 << i);
            settle;
            check({vaddr, 15'h0, creq}, {WKT_VEC_RESET, 16'h1});
        end
        rsrc <= 5'h0;
        pcb <= 1'b0;
        settle;
        check(32'(vreq), 32'h0);
    endtask

    task automatic run_code(input logic [2:0] code);
        int e0;
        run <= 1'b0;
        settle;
        wr(WKT_ADDR_CTRL, 32'hd8 | 32'(code));
        n_edge = 0;
        run <= 1'b1;
        wait_irq;
        check(32'(n_edge), 32'(BASE << code));
        e0 = n_edge;
        wr(WKT_ADDR_STATUS, 32'h1);
        wait_irq;
        check(32'(n_edge - e0), 32'(BASE << code));
    endtask

    task automatic t_irq;
        run <= 1'b0;
        settle;
        wr(WKT_ADDR_MASK, 32'h0);
        @(posedge clk);
        check(32'(irq), 32'h0);
        rdc(WKT_ADDR_STATUS, 32'h1);
        rdc(WKT_ADDR_CTRL, 32'h8f);
        wr(WKT_ADDR_MASK, 32'h1);
        @(posedge clk);
        check(32'(irq), 32'h1);
        wr(WKT_ADDR_STATUS, 32'h1);
        @(posedge clk);
        check(32'(irq), 32'h0);
    endtask

    task automatic t_wake;
        run_code(3'h0);
        run <= 1'b0;
        settle;
        check({vaddr, 15'h0, vreq}, {WKT_VEC_WAKEUP, 16'h1});
        vtaken <= 1'b1;
        @(posedge clk);
        vtaken <= 1'b0;
        settle;
        rdc(WKT_ADDR_STATUS, 32'h0);
    endtask

    task automatic t_stop;
        logic [31:0] c0;
        wr(WKT_ADDR_CTRL, 32'h18);
        run <= 1'b1;
        repeat (40) @(posedge clk);
        wr(WKT_ADDR_CTRL, 32'h0);
        settle;
        bus(1'b0, WKT_ADDR_COUNT, 32'h0);
        c0 = rd;
        check(32'(c0 > 32'h2), 32'h1);
        repeat (40) @(posedge clk);
        rdc(WKT_ADDR_COUNT, c0);
        wr(WKT_ADDR_CTRL, 32'h10);
        rdc(WKT_ADDR_COUNT, 32'h0);
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        final_report;
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_vec;
        for (int c = 0; c < 8; c++)
            run_code(3'(c));
        t_irq;
        t_wake;
        t_stop;
        final_report;
    end
endmodule
`default_nettype wire
